// file: design/two_wire_target_receiver.sv
// Purpose: target receiver of a byte-oriented two-wire serial interface
// Assumes: apb slave on pclk; scl/sda open drain, pins sampled by pclk
// Notes: target transmit and master modes live elsewhere
//
// Overview of operation
// - answer own 7-bit address; broadcast if enabled
// - address plus write bit selects receive
// - address received sets job done, valid code
// - enter receive after lost arbitration
// - ack enable cleared: nack next data byte
// - ack enable zero: ignore address, keep watching
// - in deep sleep still match and ack address
// - after sleep match hold clock until flag cleared
// - data register need not hold sleep byte
// - code 0x60 for own address with write
// - code 0x68 after arbitration loss, own address
// - code 0x70 for broadcast address
// - code 0x78 after arbitration loss, broadcast
// - codes compared with prescaler bits masked off
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "two_wire_defines.svh"
module two_wire_target_receiver (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cke,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// clock wire, open drain
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	// data wire, open drain
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// master side and power manager
	input wire logic arb_lost,
	input wire logic deep_sleep,
	output logic wake_req,
	// event level for the core
	output logic job_done
);
	import two_wire_pkg::*;

	// register contents
	two_wire_pkg::byte_t own_addr_reg; // address and broadcast accept
	logic ack_enable_bit; // acknowledge enable
	logic begin_cond_request; // kept for the master logic
	logic end_cond_request; // kept for the master logic
	logic interface_enable_bit; // unit enable
	logic irq_enable_bit; // kept for the core's interrupt unit
	logic job_done_flag; // hardware sets, software clears
	two_wire_pkg::byte_t code_reg; // bus condition code
	logic [1:0] presc_bits; // prescaler field, software owned
	two_wire_pkg::byte_t byte_data_reg; // last received byte
	logic bad_addr; // unmapped access seen in setup

	// bus side state
	target_state_t state; // sequencer
	logic [3:0] bit_cnt; // bits of current frame
	two_wire_pkg::byte_t shift; // incoming bits
	logic addressed; // own or broadcast match in force
	logic by_bcast; // addressed by broadcast
	logic arb_seen; // master lost arbitration this frame
	logic ack_now; // decision for the current ack slot
	logic sda_drive; // pulling data wire low
	logic sleep_match; // address taken while in deep sleep

	// synchronised pins and events
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic begin_seen;
	logic end_seen;

	// apb decode
	logic wr_en; // write takes effect now
	logic flag_clear; // software writes one to job done
	logic flag_set; // hardware event
	two_wire_pkg::byte_t set_code; // code that comes with flag_set
	logic addr_match; // address byte matches
	logic bcast_hit; // address byte is broadcast and accepted

	// pins pass two flops before any logic sees them
	sync_2ff #(
		.WIDTH(2)
	) sync_2ff_i (
		.pclk(pclk),
		.presetn(presetn),
		.cke(cke),
		.d({scl_in, sda_in}),
		.q({scl_s, sda_s})
	);

	// edges and conditions on the synchronised wires
	bus_event_detect bus_event_detect_i (
		.pclk(pclk),
		.presetn(presetn),
		.cke(cke),
		.scl(scl_s),
		.sda(sda_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.begin_seen(begin_seen),
		.end_seen(end_seen)
	);

	// zero wait states; write lands in the access cycle
	assign pready = 1'b1;
	assign pslverr = psel & penable & bad_addr;
	assign wr_en = cke & psel & penable & pwrite & ~bad_addr;
	assign flag_clear = wr_en & (paddr == `OFS_CTRL) &
		pwdata[`CTRL_JOB_DONE];

	// address compare on the upper seven bits of the shifted byte
	assign bcast_hit = (shift[7:1] == `BCAST_ADDR) &
		own_addr_reg[`OWN_BCAST];
	assign addr_match = (shift[7:1] ==
		own_addr_reg[`OWN_ADDR_HI:`OWN_ADDR_LO]) | bcast_hit;

	// read data and unmapped flag captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
			bad_addr <= 1'b0;
		end else if (cke && psel && !penable) begin
			bad_addr <= 1'b0;
			prdata <= '0;
			case (paddr)
				`OFS_OWN_ADDR: begin
					prdata[7:0] <= own_addr_reg;
				end
				`OFS_CTRL: begin
					prdata[`CTRL_JOB_DONE] <= job_done_flag;
					prdata[`CTRL_ACK_EN] <= ack_enable_bit;
					prdata[`CTRL_BEGIN] <= begin_cond_request;
					prdata[`CTRL_END] <= end_cond_request;
					prdata[`CTRL_IF_EN] <= interface_enable_bit;
					prdata[`CTRL_IRQ_EN] <= irq_enable_bit;
				end
				`OFS_STATUS: begin
					// code bits and prescaler bits kept apart
					prdata[7:0] <= code_reg | {6'h00, presc_bits};
				end
				`OFS_DATA: begin
					prdata[7:0] <= byte_data_reg;
				end
				default: begin
					bad_addr <= 1'b1;
				end
			endcase
		end
	end

	// software owned register bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			own_addr_reg <= `RST_BYTE;
			ack_enable_bit <= 1'b0;
			begin_cond_request <= 1'b0;
			end_cond_request <= 1'b0;
			interface_enable_bit <= 1'b0;
			irq_enable_bit <= 1'b0;
			presc_bits <= 2'h0;
		end else if (wr_en) begin
			case (paddr)
				`OFS_OWN_ADDR: begin
					own_addr_reg <= pwdata[7:0];
				end
				`OFS_CTRL: begin
					// software sets enable and ack, requests at zero
					ack_enable_bit <= pwdata[`CTRL_ACK_EN];
					begin_cond_request <= pwdata[`CTRL_BEGIN];
					end_cond_request <= pwdata[`CTRL_END];
					interface_enable_bit <= pwdata[`CTRL_IF_EN];
					irq_enable_bit <= pwdata[`CTRL_IRQ_EN];
				end
				`OFS_STATUS: begin
					presc_bits <= pwdata[1:0];
				end
				default: begin
					// data register is read only in this mode
				end
			endcase
		end
	end

	// job done: a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			job_done_flag <= 1'b0;
		end else if (cke) begin
			if (flag_set) begin
				job_done_flag <= 1'b1;
			end else if (flag_clear) begin
				job_done_flag <= 1'b0;
			end
		end
	end

	// condition code follows each flag event
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			code_reg <= `CODE_IDLE;
		end else if (cke) begin
			if (flag_set) begin
				code_reg <= set_code & `STAT_CODE_MASK;
			end else if (flag_clear) begin
				code_reg <= `CODE_IDLE;
			end
		end
	end

	// lost arbitration is remembered until the next address or end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arb_seen <= 1'b0;
		end else if (cke) begin
			if (arb_lost) begin
				arb_seen <= 1'b1;
			end else if (end_seen ||
				(state == T_ADDR_ACK && scl_fall)) begin
				arb_seen <= 1'b0;
			end
		end
	end

	// flag events and their codes
	always_comb begin
		flag_set = 1'b0;
		set_code = `CODE_IDLE;
		if (state == T_ADDR_ACK && scl_fall && ack_now) begin
			flag_set = 1'b1;
			if (by_bcast) begin
				set_code = arb_seen ? `CODE_ARB_BCAST :
					`CODE_BCAST;
			end else begin
				set_code = arb_seen ? `CODE_ARB_OWN_W :
					`CODE_OWN_W;
			end
		end else if (state == T_DATA_ACK && scl_fall) begin
			flag_set = 1'b1;
			if (by_bcast) begin
				set_code = ack_now ? `CODE_BC_DATA_ACK :
					`CODE_BC_DATA_NACK;
			end else begin
				set_code = ack_now ? `CODE_OWN_DATA_ACK :
					`CODE_OWN_DATA_NACK;
			end
		end else if (addressed && (begin_seen || end_seen) &&
			state != T_ADDR_ACK) begin
			flag_set = 1'b1;
			set_code = `CODE_STOP_ADDR;
		end
	end

	// target sequencer; clock edges arrive two cycles late via sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= T_IDLE;
			bit_cnt <= `BIT_CNT_ZERO;
			shift <= `RST_BYTE;
			addressed <= 1'b0;
			by_bcast <= 1'b0;
			ack_now <= 1'b0;
		end else if (cke) begin
			if (!interface_enable_bit) begin
				// disabled unit leaves the wires alone
				state <= T_IDLE;
				addressed <= 1'b0;
			end else if (begin_seen) begin
				// a begin or repeated begin always restarts addressing
				state <= T_ADDR;
				bit_cnt <= `BIT_CNT_ZERO;
				addressed <= 1'b0;
			end else if (end_seen) begin
				state <= T_IDLE;
				addressed <= 1'b0;
			end else begin
				case (state)
					T_IDLE: begin
						// wait for a begin condition
					end
					T_ADDR: begin
						if (scl_rise) begin
							shift <= {shift[6:0], sda_s};
							bit_cnt <= bit_cnt + `BIT_CNT_ONE;
						end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
							// write bit, match and ack enable
							ack_now <= addr_match & ~shift[0] &
								ack_enable_bit;
							by_bcast <= bcast_hit;
							state <= T_ADDR_ACK;
						end
					end
					T_ADDR_ACK: begin
						if (scl_fall) begin
							// read direction belongs to transmit mode
							addressed <= ack_now;
							state <= ack_now ? T_HOLD : T_IDLE;
						end
					end
					T_HOLD: begin
						if (!job_done_flag) begin
							bit_cnt <= `BIT_CNT_ZERO;
							state <= addressed ? T_DATA : T_IDLE;
						end
					end
					T_DATA: begin
						if (scl_rise) begin
							shift <= {shift[6:0], sda_s};
							bit_cnt <= bit_cnt + `BIT_CNT_ONE;
						end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
							// ack taken from the bit as it is now
							ack_now <= ack_enable_bit;
							state <= T_DATA_ACK;
						end
					end
					T_DATA_ACK: begin
						if (scl_fall) begin
							// after a nack the target stops listening
							addressed <= ack_now;
							state <= T_HOLD;
						end
					end
					default: begin
						state <= T_IDLE;
					end
				endcase
			end
		end
	end

	// received bytes; the address is not kept when taken in sleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			byte_data_reg <= `RST_BYTE;
		end else if (cke && scl_fall) begin
			if (state == T_DATA_ACK) begin
				byte_data_reg <= shift;
			end else if (state == T_ADDR_ACK && !deep_sleep) begin
				byte_data_reg <= shift;
			end
		end
	end

	// sleep match raises wake until software clears job done
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_match <= 1'b0;
		end else if (cke) begin
			if (state == T_ADDR_ACK && scl_fall && ack_now &&
				deep_sleep) begin
				sleep_match <= 1'b1;
			end else if (flag_clear) begin
				sleep_match <= 1'b0;
			end
		end
	end

	// data wire pulled low only for an ack slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sda_drive <= 1'b0;
		end else if (cke) begin
			if (!interface_enable_bit || begin_seen || end_seen) begin
				sda_drive <= 1'b0;
			end else if (scl_fall && bit_cnt == `BITS_PER_BYTE &&
				(state == T_ADDR || state == T_DATA)) begin
				// a nack is a released, high data wire
				sda_drive <= (state == T_ADDR) ?
					(addr_match & ~shift[0] & ack_enable_bit) :
					ack_enable_bit;
			end else if (scl_fall) begin
				sda_drive <= 1'b0;
			end
		end
	end

	// open drain: output level always low, enable does the work
	assign sda_out = 1'b0;
	assign sda_oe = sda_drive;
	assign scl_out = 1'b0;
	// long wakeups stretch the clock and can block the bus for that time
	assign scl_oe = (state == T_HOLD) & job_done_flag;
	assign wake_req = sleep_match;
	assign job_done = job_done_flag;
endmodule // two_wire_target_receiver

// file: design/two_wire_defines.svh
// Purpose: named offsets, bit positions and codes of the two-wire target
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only
`ifndef TWO_WIRE_DEFINES_SVH
`define TWO_WIRE_DEFINES_SVH

// apb register byte addresses
`define OFS_OWN_ADDR 12'h000
`define OFS_CTRL 12'h004
`define OFS_STATUS 12'h008
`define OFS_DATA 12'h00C

// control register bit positions
`define CTRL_JOB_DONE 7
`define CTRL_ACK_EN 6
`define CTRL_BEGIN 5
`define CTRL_END 4
`define CTRL_WCOL 3
`define CTRL_IF_EN 2
`define CTRL_IRQ_EN 0

// own address register fields
`define OWN_ADDR_HI 7
`define OWN_ADDR_LO 1
`define OWN_BCAST 0

// status register fields
`define STAT_CODE_MASK 8'hF8
`define STAT_PRESC_MASK 8'h03

// reset values
`define RST_BYTE 8'h00

// broadcast address and bit count of one frame
`define BCAST_ADDR 7'h00
`define BITS_PER_BYTE 4'h8
`define BIT_CNT_ZERO 4'h0
`define BIT_CNT_ONE 4'h1

// bus condition codes, prescaler bits zero
`define CODE_IDLE 8'hF8
`define CODE_OWN_W 8'h60
`define CODE_ARB_OWN_W 8'h68
`define CODE_BCAST 8'h70
`define CODE_ARB_BCAST 8'h78
`define CODE_OWN_DATA_ACK 8'h80
`define CODE_OWN_DATA_NACK 8'h88
`define CODE_BC_DATA_ACK 8'h90
`define CODE_BC_DATA_NACK 8'h98
`define CODE_STOP_ADDR 8'hA0

`endif

// file: design/two_wire_pkg.sv
// Purpose: shared types of the two-wire target receiver
// Assumes: nothing
// Notes: numbers live in two_wire_defines.svh
package two_wire_pkg;

	// one byte on the bus or at the registers
	typedef logic [7:0] byte_t;

	// target receiver sequencing
	typedef enum logic [2:0] {
		T_IDLE,
		T_ADDR,
		T_ADDR_ACK,
		T_HOLD,
		T_DATA,
		T_DATA_ACK
	} target_state_t;

endpackage

// file: design/sync_2ff.sv
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to pclk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module sync_2ff #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cke,
	// levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta; // first stage, read by q only

	// pins idle high, so reset to ones to avoid a false start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= '1;
			q <= '1;
		end else if (cke) begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // sync_2ff

// file: design/bus_event_detect.sv
// Purpose: finds clock edges and begin/end conditions on the two wires
// Assumes: scl and sda already synchronised to pclk
// Notes: all outputs are one-cycle pulses
`timescale 1ns/1ps
module bus_event_detect (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cke,
	// synchronised bus levels
	input wire logic scl,
	input wire logic sda,
	// events
	output logic scl_rise,
	output logic scl_fall,
	output logic begin_seen,
	output logic end_seen
);
	logic scl_q; // previous clock level
	logic sda_q; // previous data level

	// remember last levels
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (cke) begin
			scl_q <= scl;
			sda_q <= sda;
		end
	end

	// data may only change while clock is high for a condition
	assign scl_rise = cke & scl & ~scl_q;
	assign scl_fall = cke & ~scl & scl_q;
	assign begin_seen = cke & scl & scl_q & sda_q & ~sda;
	assign end_seen = cke & scl & scl_q & ~sda_q & sda;
endmodule // bus_event_detect

// file: tb/two_wire_target_receiver_assertions.sv
// Purpose: port checks of the two-wire target receiver
// Assumes: bound into two_wire_target_receiver, pclk domain only
// Notes: bus events are judged by their effects on the pins
`timescale 1ns/1ps
`include "two_wire_defines.svh"
module two_wire_target_receiver_assertions (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic cke,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// wires and core side
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic deep_sleep,
	input wire logic wake_req,
	input wire logic job_done
);
	// software writes a one to the flag bit
	logic clr_wr;
	assign clr_wr = psel && penable && pwrite && cke &&
		paddr == `OFS_CTRL && pwdata[`CTRL_JOB_DONE];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_zero_wait: assert property (psel && !penable |=> pready)
		else $error("access phase without ready");
	a_unmapped_err: assert property (psel && penable && !(paddr inside
		{`OFS_OWN_ADDR, `OFS_CTRL, `OFS_STATUS, `OFS_DATA}) |-> pslverr)
		else $error("unmapped access not refused");
	a_flag_holds: assert property (
		job_done && !clr_wr |=> job_done)
		else $error("flag dropped without a clear");
	a_clear_release: assert property (
		clr_wr |=> !scl_oe && !wake_req)
		else $error("clock still held after clear");
	a_ack_width: assert property (
		$rose(sda_oe) |-> sda_oe[*4])
		else $error("ack pulse too short");
	a_flag_after_ack: assert property (
		$fell(sda_oe) |-> ##[0:4] job_done)
		else $error("no flag after ack clock");
	a_stretch_after: assert property (
		$fell(sda_oe) |-> ##[0:4] scl_oe)
		else $error("clock not held after ack");
	a_wake_sleep: assert property (
		$rose(wake_req) |-> $past(deep_sleep))
		else $error("wake request outside sleep");
endmodule // two_wire_target_receiver_assertions

bind two_wire_target_receiver two_wire_target_receiver_assertions
	two_wire_target_receiver_assertions_i (.pclk(pclk),
	.presetn(presetn), .cke(cke), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .scl_oe(scl_oe), .sda_oe(sda_oe),
	.deep_sleep(deep_sleep), .wake_req(wake_req), .job_done(job_done));

// file: tb/two_wire_bus_ctrl.sv
// Purpose: remote bus controller sending frames as transmitter
// Assumes: open-drain wires with pull-ups, 200 ns bit period
// Notes: waits out a clock line held low by the target
`timescale 1ns/1ps
module two_wire_bus_ctrl (
	// wire levels
	input wire logic scl,
	input wire logic sda,
	// pulls, high drives the wire low
	output logic scl_pull,
	output logic sda_pull
);
	// quarter of a bit period
	localparam int QTR = 50;
	// idle bus: both wires released, clock stands still
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end
	// data falls while clock is high
	task automatic begin_frame();
		sda_pull = 1'b1;
		#(2*QTR);
		scl_pull = 1'b1;
		#QTR;
	endtask
	// data only moves a quarter after the fall, so no false condition
	task automatic pulse(output logic lvl);
		#QTR;
		scl_pull = 1'b0;
		wait (scl === 1'b1);
		#QTR;
		lvl = sda;
		#QTR;
		scl_pull = 1'b1;
		#QTR;
	endtask
	// eight bits msb first, then the ack clock with data released
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic lvl;
		for (int i = 7; i >= 0; i--) begin
			sda_pull = !b[i];
			pulse(lvl);
		end
		sda_pull = 1'b0;
		pulse(lvl);
		ack = !lvl;
	endtask
	// data rises while clock is high
	task automatic end_frame();
		sda_pull = 1'b1;
		#QTR;
		scl_pull = 1'b0;
		wait (scl === 1'b1);
		#QTR;
		sda_pull = 1'b0;
		#(2*QTR);
	endtask
endmodule // two_wire_bus_ctrl

// file: tb/two_wire_target_receiver_tb.sv
// Purpose: self-checking bench of the two-wire target receiver
// Assumes: bus controller model on the far side of both wires
// Notes: own address 7'h2D, status prescaler kept at 3
`timescale 1ns/1ps
`include "two_wire_defines.svh"
module two_wire_target_receiver_tb;
	logic pclk, presetn, cke, psel, penable, pwrite, arb_lost, deep_sleep;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe;
	logic wake_req, job_done, scl_pull, sda_pull;
	int failures, n_tests;
	// open-drain wires with pull-ups
	// an enabled pin shows the design's output level
	wire scl_w = !scl_pull && (scl_oe ? scl_out : 1'b1);
	wire sda_w = !sda_pull && (sda_oe ? sda_out : 1'b1);
	two_wire_target_receiver two_wire_target_receiver_i (.pclk(pclk),
		.presetn(presetn), .cke(cke), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .scl_in(scl_w),
		.scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
		.sda_out(sda_out), .sda_oe(sda_oe), .arb_lost(arb_lost),
		.deep_sleep(deep_sleep), .wake_req(wake_req), .job_done(job_done));
	two_wire_bus_ctrl two_wire_bus_ctrl_i (.scl(scl_w), .sda(sda_w),
		.scl_pull(scl_pull), .sda_pull(sda_pull));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic conclude();
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic check_pin(input logic got, input logic exp);
		check({31'h0, got}, {31'h0, exp});
	endtask
	// one apb transfer, held until ready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0, q, e);
		check(q, exp);
	endtask
	// bounded wait for the flag
	task automatic wait_flag();
		for (int n = 0; n < 200 && job_done !== 1'b1; n++) @(posedge pclk);
	endtask
	// one byte; unless an address goes unanswered, check flag, code, data, then clear
	task automatic step(input logic [7:0] b, input logic first,
		input logic exp_ack, input logic [7:0] code, input logic [7:0] nxt);
		logic ack;
		if (first) two_wire_bus_ctrl_i.begin_frame();
		two_wire_bus_ctrl_i.put_byte(b, ack);
		check_pin(ack, exp_ack);
		if (exp_ack || !first) begin
			wait_flag();
			check_pin(job_done, 1'b1);
			check_pin(scl_oe, 1'b1);
			check_pin(wake_req, deep_sleep);
			rd_chk(`OFS_STATUS, {24'h0, code} | 32'h0000_0003);
			if (!deep_sleep) rd_chk(`OFS_DATA, {24'h0, b});
			wr(`OFS_CTRL, {24'h0, nxt});
			@(posedge pclk);
			check_pin(scl_oe, 1'b0);
		end
	endtask
	// stop; an addressed target reports it and is cleared
	task automatic close(input logic addressed);
		two_wire_bus_ctrl_i.end_frame();
		if (addressed) begin
			wait_flag();
			rd_chk(`OFS_STATUS, 32'h0000_00A3);
			wr(`OFS_CTRL, 32'h0000_00C4);
		end
	endtask
	// reset values, access kinds, unmapped word
	task automatic regs_test();
		logic [31:0] q;
		logic e;
		rd_chk(`OFS_OWN_ADDR, 32'h0);
		rd_chk(`OFS_CTRL, 32'h0);
		rd_chk(`OFS_STATUS, 32'h0000_00F8);
		apb(1'b1, 12'h010, 32'h0000_00FF, q, e);
		check_pin(e, 1'b1);
		wr(`OFS_CTRL, 32'h0000_007F);
		rd_chk(`OFS_CTRL, 32'h0000_0075);
		wr(`OFS_STATUS, 32'h0000_0003);
		wr(`OFS_OWN_ADDR, 32'h0000_005A);
		rd_chk(`OFS_OWN_ADDR, 32'h0000_005A);
		// enable low freezes the registers: the write is not taken
		cke <= 1'b0;
		wr(`OFS_OWN_ADDR, 32'h0000_00FF);
		cke <= 1'b1;
		rd_chk(`OFS_OWN_ADDR, 32'h0000_005A);
		wr(`OFS_CTRL, 32'h0000_0044);
	endtask
	task automatic own_test();
		step(8'h5A, 1'b1, 1'b1, 8'h60, 8'hC4);
		step(8'hA5, 1'b0, 1'b1, 8'h80, 8'h84);
		step(8'h3C, 1'b0, 1'b0, 8'h88, 8'hC4);
		close(1'b0);
	endtask
	task automatic codes_test();
		logic [7:0] b [4] = '{8'h5A, 8'h5A, 8'h00, 8'h00};
		logic [7:0] c [4] = '{8'h60, 8'h68, 8'h70, 8'h78};
		wr(`OFS_OWN_ADDR, 32'h0000_005B);
		for (int i = 0; i < 4; i++) begin
			arb_lost <= i[0];
			// last pass turns ack off to see the broadcast nack code
			step(b[i], 1'b1, 1'b1, c[i],
				i == 3 ? 8'h84 : 8'hC4);
			arb_lost <= 1'b0;
			step(8'h11, 1'b0, i != 3, i < 2 ? 8'h80 :
				(i == 3 ? 8'h98 : 8'h90), 8'hC4);
			close(i != 3);
		end
	endtask
	// broadcast refused, read direction, other address
	task automatic ignore_test();
		logic [7:0] b [3] = '{8'h00, 8'h5B, 8'h5C};
		wr(`OFS_OWN_ADDR, 32'h0000_005A);
		foreach (b[i]) begin
			step(b[i], 1'b1, 1'b0, 8'h00, 8'h00);
			close(1'b0);
			check_pin(job_done, 1'b0);
		end
	endtask
	task automatic ack_off_test();
		wr(`OFS_CTRL, 32'h0000_0004);
		step(8'h5A, 1'b1, 1'b0, 8'h00, 8'h00);
		close(1'b0);
		wr(`OFS_CTRL, 32'h0000_0044);
		step(8'h5A, 1'b1, 1'b1, 8'h60, 8'hC4);
		close(1'b1);
	endtask
	task automatic sleep_test();
		deep_sleep <= 1'b1;
		step(8'h5A, 1'b1, 1'b1, 8'h60, 8'hC4);
		deep_sleep <= 1'b0;
		close(1'b1);
	endtask
	initial begin
		failures = 0;
		n_tests = 0;
		presetn = 1'b0;
		cke = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		arb_lost = 1'b0;
		deep_sleep = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		regs_test();
		own_test();
		codes_test();
		ignore_test();
		ack_off_test();
		sleep_test();
		conclude();
	end
	// watchdog, far beyond the expected run
	initial begin
		#1000000;
		failures++;
		conclude();
	end
endmodule // two_wire_target_receiver_tb
